/* hw/hbp_pkg.sv */
// shared constants and types for the buffer ram programmed-io port
package hbp_pkg;
  localparam logic [6:0] CMD_ISO_PORT = 7'h40;
  localparam logic [6:0] CMD_ACK_PORT = 7'h41;
  localparam int CMD_WRITE_BIT = 7;
  localparam logic [6:0] REG_XFER_COUNT = 7'h22;
  localparam logic [6:0] REG_IRQ_FLAGS = 7'h24;
  localparam logic [6:0] REG_ISO_LENGTH = 7'h2a;
  localparam logic [6:0] REG_ACK_LENGTH = 7'h2b;
  localparam logic [6:0] REG_BUF_STATE = 7'h2c;
  localparam int IRQ_ACK_BIT = 1;
  localparam int IRQ_EOT_BIT = 2;
  localparam int ST_PING_FULL = 0;
  localparam int ST_PONG_FULL = 1;
  localparam int ST_ACK_FULL = 2;
  localparam int ST_PING_DONE = 3;
  localparam int ST_PONG_DONE = 4;
  localparam int ST_ACK_DONE = 5;
  localparam int RAM_WORDS = 2048;
  localparam logic [15:0] RST_XFER_COUNT = 16'h0000;
  localparam logic [15:0] RST_ACK_LENGTH = 16'h1000;
  localparam logic [15:0] RST_ISO_LENGTH = 16'h0000;
  localparam logic [12:0] PTR_STEP = 13'h0002;

  typedef enum logic [2:0] {
    HBP_K_REG_WR,
    HBP_K_REG_RD,
    HBP_K_PORT_WR,
    HBP_K_PORT_RD,
    HBP_K_DATA_WR,
    HBP_K_DATA_RD
  } hbp_kind_t;
endpackage

/* hw/hbp_bus_if.sv */
// command/data parallel bus between host processor and buffer port
`timescale 1ns/100ps
`default_nettype none
interface hbp_bus_if;
  logic cmd_sel;
  logic wr;
  logic rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport dev (input cmd_sel, input wr, input rd, input wdata, output rdata);
  modport host (output cmd_sel, output wr, output rd, output wdata, input rdata);
endinterface
`default_nettype wire

/* hw/hbp_device.sv */
// device end: register file, buffer ram and its programmed-io ports
//
// Functional notes
// - iso list port: 40h read, c0h write
// - ack list port: 41h read, c1h write
// - each word moves two bytes, pointer +2
// - low byte even location, high byte odd
// - one command, then accesses until the pointer reaches the count
// - pointer reaching count sets done flag, status
// - start of frame swaps iso halves
// - both halves full: no swap, use pong
// - count covers headers and payload space
// - byte total above packet limit is accepted
// - ack write done sets ack full flag
// - ack processed flag only while running
// - processed ack list raises ack flag
// - writing one clears end-of-transfer flag
// - read-only buffer state at 2ch
// - iso write sets that half's full flag
// - iso read clears that half's status
`timescale 1ns/100ps
`default_nettype none
module hbp_device
  import hbp_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // processor bus
  hbp_bus_if.dev bus,
  // controller side
  input wire logic sof_i,
  input wire logic bus_running_i,
  input wire logic ack_list_serviced_i,
  // status
  output logic [5:0] buffer_state_o,
  output logic all_transfers_done_o,
  output logic ack_list_irq_o,
  output logic iso_cpu_half_o
);
  typedef enum logic [2:0] {
    HBP_M_IDLE,
    HBP_M_REG,
    HBP_M_ISO_WR,
    HBP_M_ISO_RD,
    HBP_M_ACK_WR,
    HBP_M_ACK_RD
  } hbp_mode_t;

  typedef struct packed {
    hbp_mode_t mode;
    logic [6:0] idx;
    logic idx_wr;
    logic [12:0] ptr;
    logic [15:0] xfer_count;
    logic [15:0] ack_len;
    logic [15:0] iso_len;
    logic eot_flag;
    logic ack_flag;
    logic [5:0] state;
    logic cpu_half;
    logic [15:0] rdata;
  } hbp_dev_t;

  hbp_dev_t s_r;
  hbp_dev_t s_nxt;
  logic [15:0] mem [0:RAM_WORDS-1];
  logic ram_we;
  logic [10:0] ram_waddr;
  logic [11:0] base;
  logic [11:0] byte_addr;
  logic [12:0] ptr_step;
  logic [5:0] st_old;

  function automatic logic [15:0] reg_read(input hbp_dev_t s, input logic [6:0] i);
    logic [15:0] v;
    v = 16'h0000;
    case (i)
      REG_XFER_COUNT: v = s.xfer_count;
      REG_IRQ_FLAGS: begin
        v[IRQ_ACK_BIT] = s.ack_flag;
        v[IRQ_EOT_BIT] = s.eot_flag;
      end
      REG_ISO_LENGTH: v = s.iso_len;
      REG_ACK_LENGTH: v = s.ack_len;
      REG_BUF_STATE: v = {10'h000, s.state};
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // ack list sits at the bottom, the two iso halves follow it
  always_comb begin
    case (s_r.mode)
      HBP_M_ISO_WR, HBP_M_ISO_RD: begin
        base = s_r.ack_len[11:0] + (s_r.cpu_half ? s_r.iso_len[11:0] : 12'h000);
      end
      default: base = 12'h000;
    endcase
    byte_addr = base + s_r.ptr[11:0];
    ram_waddr = byte_addr[11:1];
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = 16'h0000;
    ram_we = 1'b0;
    ptr_step = s_r.ptr + PTR_STEP;
    st_old = s_r.state;
    if (bus.wr && bus.cmd_sel) begin
      s_nxt.ptr = 13'h0000;
      s_nxt.idx = bus.wdata[6:0];
      s_nxt.idx_wr = bus.wdata[CMD_WRITE_BIT];
      if (bus.wdata[6:0] == CMD_ISO_PORT) begin
        s_nxt.mode = bus.wdata[CMD_WRITE_BIT] ? HBP_M_ISO_WR : HBP_M_ISO_RD;
      end else if (bus.wdata[6:0] == CMD_ACK_PORT) begin
        s_nxt.mode = bus.wdata[CMD_WRITE_BIT] ? HBP_M_ACK_WR : HBP_M_ACK_RD;
        if (bus.wdata[CMD_WRITE_BIT]) begin
          s_nxt.state[ST_ACK_FULL] = 1'b0;
          s_nxt.state[ST_ACK_DONE] = 1'b0;
        end
      end else begin
        s_nxt.mode = HBP_M_REG;
      end
    end else if (bus.wr || bus.rd) begin
      case (s_r.mode)
        HBP_M_REG: begin
          s_nxt.mode = HBP_M_IDLE;
          if (bus.rd && !s_r.idx_wr) begin
            s_nxt.rdata = reg_read(s_r, s_r.idx);
          end else if (bus.wr && s_r.idx_wr) begin
            case (s_r.idx)
              // no check against any packet limit: long descriptors pass
              REG_XFER_COUNT: s_nxt.xfer_count = bus.wdata;
              REG_IRQ_FLAGS: begin
                if (bus.wdata[IRQ_EOT_BIT]) begin
                  s_nxt.eot_flag = 1'b0;
                end
                if (bus.wdata[IRQ_ACK_BIT]) begin
                  s_nxt.ack_flag = 1'b0;
                end
              end
              REG_ISO_LENGTH: s_nxt.iso_len = bus.wdata;
              REG_ACK_LENGTH: s_nxt.ack_len = bus.wdata;
              default: s_nxt.idx = s_r.idx;
            endcase
          end
        end
        HBP_M_ISO_WR, HBP_M_ACK_WR, HBP_M_ISO_RD, HBP_M_ACK_RD: begin
          // streaming goes on until the pointer reaches the count
          if (bus.wr && (s_r.mode == HBP_M_ISO_WR || s_r.mode == HBP_M_ACK_WR)) begin
            ram_we = 1'b1;
          end
          if (bus.rd) begin
            s_nxt.rdata = mem[ram_waddr];
            if (s_r.mode == HBP_M_ISO_RD) begin
              // one word read back releases the half
              if (s_r.cpu_half) begin
                s_nxt.state[ST_PONG_FULL] = 1'b0;
                s_nxt.state[ST_PONG_DONE] = 1'b0;
              end else begin
                s_nxt.state[ST_PING_FULL] = 1'b0;
                s_nxt.state[ST_PING_DONE] = 1'b0;
              end
            end
          end
          s_nxt.ptr = ptr_step;
          if ({3'b000, ptr_step} >= s_r.xfer_count) begin
            s_nxt.mode = HBP_M_IDLE;
            s_nxt.eot_flag = 1'b1;
            if (s_r.mode == HBP_M_ACK_WR) begin
              s_nxt.state[ST_ACK_FULL] = 1'b1;
            end
            if (s_r.mode == HBP_M_ISO_WR) begin
              s_nxt.state[s_r.cpu_half ? ST_PONG_FULL : ST_PING_FULL] = 1'b1;
            end
          end
        end
        default: s_nxt.mode = HBP_M_IDLE;
      endcase
    end
    if (sof_i) begin
      // a half left unread for a whole frame is dropped; its full and done flags clear so iso flow goes on
      if (st_old[ST_PING_DONE] && !s_r.cpu_half) begin
        s_nxt.state[ST_PING_DONE] = 1'b0;
        s_nxt.state[ST_PING_FULL] = 1'b0;
      end
      if (st_old[ST_PONG_DONE] && s_r.cpu_half) begin
        s_nxt.state[ST_PONG_DONE] = 1'b0;
        s_nxt.state[ST_PONG_FULL] = 1'b0;
      end
      if (s_r.cpu_half && st_old[ST_PING_FULL]) begin
        s_nxt.state[ST_PING_DONE] = 1'b1;
      end
      if (!s_r.cpu_half && st_old[ST_PONG_FULL]) begin
        s_nxt.state[ST_PONG_DONE] = 1'b1;
      end
      if (st_old[ST_PING_FULL] && st_old[ST_PONG_FULL]) begin
        s_nxt.cpu_half = 1'b1;
      end else begin
        s_nxt.cpu_half = ~s_r.cpu_half;
      end
    end
    if (!bus_running_i) begin
      s_nxt.state[ST_ACK_DONE] = 1'b0;
    end else if (ack_list_serviced_i && s_r.state[ST_ACK_FULL]) begin
      s_nxt.state[ST_ACK_DONE] = 1'b1;
      s_nxt.ack_flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      s_r <= '0;
      s_r.xfer_count <= RST_XFER_COUNT;
      s_r.ack_len <= RST_ACK_LENGTH;
      s_r.iso_len <= RST_ISO_LENGTH;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ram keeps no reset: contents are undefined until written
  always_ff @(posedge core_clk_i) begin
    if (ram_we) begin
      mem[ram_waddr] <= bus.wdata;
    end
  end

  assign bus.rdata = s_r.rdata;
  assign buffer_state_o = s_r.state;
  assign all_transfers_done_o = s_r.eot_flag;
  assign ack_list_irq_o = s_r.ack_flag;
  assign iso_cpu_half_o = s_r.cpu_half;
endmodule
`default_nettype wire

/* hw/hbp_host.sv */
// host end: turns user requests into command and data bus cycles
`timescale 1ns/100ps
`default_nettype none
module hbp_host
  import hbp_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // processor bus
  hbp_bus_if.host bus,
  // user requests
  input wire logic req_i,
  input wire hbp_kind_t req_kind_i,
  input wire logic [6:0] req_index_i,
  input wire logic [15:0] req_data_i,
  // user answers
  output logic busy_o,
  output logic [15:0] rsp_data_o,
  output logic rsp_valid_o
);
  typedef enum logic [1:0] {
    HBP_H_IDLE,
    HBP_H_CMD,
    HBP_H_WAIT,
    HBP_H_TAKE
  } hbp_hst_t;

  typedef struct packed {
    hbp_hst_t st;
    logic pend_wr;
    logic [15:0] data;
    logic cmd_sel;
    logic wr;
    logic rd;
    logic [15:0] wdata;
    logic busy;
    logic [15:0] rsp;
    logic rsp_valid;
  } hbp_host_t;

  hbp_host_t s_r;
  hbp_host_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.wr = 1'b0;
    s_nxt.rd = 1'b0;
    s_nxt.rsp_valid = 1'b0;
    case (s_r.st)
      HBP_H_IDLE: begin
        if (req_i) begin
          s_nxt.data = req_data_i;
          case (req_kind_i)
            HBP_K_DATA_WR: begin
              s_nxt.cmd_sel = 1'b0;
              s_nxt.wr = 1'b1;
              s_nxt.wdata = req_data_i;
            end
            HBP_K_DATA_RD: begin
              s_nxt.cmd_sel = 1'b0;
              s_nxt.rd = 1'b1;
              s_nxt.st = HBP_H_WAIT;
            end
            HBP_K_PORT_WR, HBP_K_PORT_RD: begin
              // port command goes out once, data accesses follow freely
              s_nxt.cmd_sel = 1'b1;
              s_nxt.wr = 1'b1;
              s_nxt.wdata = {8'h00, (req_kind_i == HBP_K_PORT_WR), req_index_i};
            end
            default: begin
              s_nxt.cmd_sel = 1'b1;
              s_nxt.wr = 1'b1;
              s_nxt.pend_wr = (req_kind_i == HBP_K_REG_WR);
              s_nxt.wdata = {8'h00, (req_kind_i == HBP_K_REG_WR), req_index_i};
              s_nxt.st = HBP_H_CMD;
            end
          endcase
        end
      end
      HBP_H_CMD: begin
        s_nxt.cmd_sel = 1'b0;
        if (s_r.pend_wr) begin
          s_nxt.wr = 1'b1;
          s_nxt.wdata = s_r.data;
          s_nxt.st = HBP_H_IDLE;
        end else begin
          s_nxt.rd = 1'b1;
          s_nxt.st = HBP_H_WAIT;
        end
      end
      HBP_H_WAIT: begin
        // the device answers one edge after it sees the read strobe, so wait for it
        s_nxt.st = HBP_H_TAKE;
      end
      HBP_H_TAKE: begin
        s_nxt.rsp = bus.rdata;
        s_nxt.rsp_valid = 1'b1;
        s_nxt.st = HBP_H_IDLE;
      end
      default: s_nxt.st = HBP_H_IDLE;
    endcase
    s_nxt.busy = (s_nxt.st != HBP_H_IDLE);
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.cmd_sel = s_r.cmd_sel;
  assign bus.wr = s_r.wr;
  assign bus.rd = s_r.rd;
  assign bus.wdata = s_r.wdata;
  assign busy_o = s_r.busy;
  assign rsp_data_o = s_r.rsp;
  assign rsp_valid_o = s_r.rsp_valid;
endmodule
`default_nettype wire

/* tb/hbp_bus_asserts.sv */
// wire-level checks of the command/data bus between the two ends
`timescale 1ns/100ps
`default_nettype none
module hbp_bus_asserts (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // bus signals
  input wire logic cmd_sel,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_cmd_any;
    cmd_sel && wr;
  endsequence
  // port codes 40h/41h are single-cycle, so they are left out of the register pairs
  sequence s_reg_cmd_wr;
    cmd_sel && wr && wdata[7] && wdata[6:1] != 6'h20;
  endsequence
  sequence s_reg_cmd_rd;
    cmd_sel && wr && !wdata[7] && wdata[6:1] != 6'h20;
  endsequence
  sequence s_state_rd;
    cmd_sel && wr && wdata[7:0] == 8'h2c ##1 rd;
  endsequence
  sequence s_hole_rd;
    cmd_sel && wr && wdata[7:0] == 8'h7f ##1 rd;
  endsequence
  a_strobe_excl: assert property (!(wr && rd)) else $error("both strobes high");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000) else $error("rdata outside slot");
  a_reg_wr_pair: assert property (s_reg_cmd_wr |=> wr && !cmd_sel) else $error("no data write");
  a_reg_rd_pair: assert property (s_reg_cmd_rd |=> rd && !cmd_sel) else $error("no data read");
  a_cmd_upper: assert property (s_cmd_any |-> wdata[15:8] == 8'h00) else $error("command upper byte");
  a_rd_data_port: assert property (rd |-> !cmd_sel) else $error("read on command port");
  a_state_width: assert property (s_state_rd |=> rdata[15:6] == 10'h000) else $error("state bits");
  a_hole_zero: assert property (s_hole_rd |=> rdata == 16'h0000) else $error("unmapped read");
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for host and device ends joined on one bus
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import hbp_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic sof_i = 1'b0, run_i = 1'b0, svc_i = 1'b0, req_i = 1'b0;
  hbp_kind_t kind = HBP_K_REG_WR;
  logic [6:0] idx = 7'h00;
  logic [15:0] wd = 16'h0000;
  logic busy, rsp_v, end_of_transfer, ackirq, half;
  logic [15:0] rsp;
  logic [15:0] got = 16'h0000;
  logic [5:0] st;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  hbp_bus_if bus_if ();
  hbp_device hbp_device_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .bus(bus_if.dev), .sof_i(sof_i),
    .bus_running_i(run_i), .ack_list_serviced_i(svc_i), .buffer_state_o(st), .all_transfers_done_o(end_of_transfer),
    .ack_list_irq_o(ackirq), .iso_cpu_half_o(half));
  hbp_host hbp_host_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .bus(bus_if.host), .req_i(req_i),
    .req_kind_i(kind), .req_index_i(idx), .req_data_i(wd), .busy_o(busy), .rsp_data_o(rsp), .rsp_valid_o(rsp_v));
  hbp_bus_asserts hbp_bus_asserts_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .cmd_sel(bus_if.cmd_sel),
    .wr(bus_if.wr), .rd(bus_if.rd), .wdata(bus_if.wdata), .rdata(bus_if.rdata));
  initial forever #10 core_clk_i = ~core_clk_i;
  // read results are taken only in the cycle the host flags them
  always @(posedge core_clk_i) if (rsp_v === 1'b1) got <= rsp;
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // longest request answers at c4, so five idle edges always cover it
  task automatic issue(input hbp_kind_t k, input logic [6:0] i, input logic [15:0] d);
    logic exp_busy;
    exp_busy = (k == HBP_K_REG_WR || k == HBP_K_REG_RD || k == HBP_K_DATA_RD);
    @(posedge core_clk_i);
    kind <= k;
    idx <= i;
    wd <= d;
    req_i <= 1'b1;
    @(posedge core_clk_i);
    req_i <= 1'b0;
    #1;
    cmp({15'h0000, busy}, {15'h0000, exp_busy});
    repeat (5) @(posedge core_clk_i);
    #1;
  endtask
  task automatic pulse(input logic is_sof);
    @(posedge core_clk_i);
    sof_i <= is_sof;
    svc_i <= !is_sof;
    @(posedge core_clk_i);
    sof_i <= 1'b0;
    svc_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask
  task automatic sc_ack_stream();
    logic [15:0] v;
    issue(HBP_K_REG_WR, REG_IRQ_FLAGS, 16'h0004);
    issue(HBP_K_REG_WR, REG_XFER_COUNT, 16'h000a);
    issue(HBP_K_PORT_WR, CMD_ACK_PORT, 16'h0000);
    v = 16'h0100;
    for (int i = 0; i < 5; i++) begin
      cmp({15'h0000, end_of_transfer}, 16'h0000);
      issue(HBP_K_DATA_WR, 7'h00, v);
      v = v + 16'h0202;
    end
    cmp({15'h0000, end_of_transfer}, 16'h0001);
    cmp({10'h000, st}, 16'h0004);
    issue(HBP_K_REG_RD, REG_IRQ_FLAGS, 16'h0000);
    cmp(got, 16'h0004);
    issue(HBP_K_REG_WR, REG_IRQ_FLAGS, 16'h0004);
    cmp({15'h0000, end_of_transfer}, 16'h0000);
    issue(HBP_K_PORT_RD, CMD_ACK_PORT, 16'h0000);
    v = 16'h0100;
    for (int i = 0; i < 5; i++) begin
      issue(HBP_K_DATA_RD, 7'h00, 16'h0000);
      cmp(got, v);
      v = v + 16'h0202;
    end
    cmp({15'h0000, end_of_transfer}, 16'h0001);
  endtask
  task automatic sc_ack_serviced();
    pulse(1'b0);
    cmp({15'h0000, st[5]}, 16'h0000);
    @(posedge core_clk_i);
    run_i <= 1'b1;
    pulse(1'b0);
    cmp({15'h0000, ackirq}, 16'h0001);
    issue(HBP_K_REG_RD, REG_IRQ_FLAGS, 16'h0000);
    cmp(got, 16'h0006);
    issue(HBP_K_REG_WR, REG_BUF_STATE, 16'h003f);
    issue(HBP_K_REG_RD, REG_BUF_STATE, 16'h0000);
    cmp(got, 16'h0024);
    issue(HBP_K_REG_RD, 7'h7f, 16'hffff);
    cmp(got, 16'h0000);
  endtask
  task automatic sc_iso_pingpong();
    issue(HBP_K_REG_WR, REG_ISO_LENGTH, 16'h0010);
    issue(HBP_K_REG_WR, REG_XFER_COUNT, 16'h0004);
    issue(HBP_K_REG_WR, REG_IRQ_FLAGS, 16'h0004);
    issue(HBP_K_PORT_WR, CMD_ISO_PORT, 16'h0000);
    issue(HBP_K_DATA_WR, 7'h00, 16'h1111);
    issue(HBP_K_DATA_WR, 7'h00, 16'h2222);
    cmp({14'h0000, half, st[0]}, 16'h0001);
    pulse(1'b1);
    cmp({15'h0000, half}, 16'h0001);
    issue(HBP_K_REG_WR, REG_IRQ_FLAGS, 16'h0004);
    issue(HBP_K_PORT_WR, CMD_ISO_PORT, 16'h0000);
    issue(HBP_K_DATA_WR, 7'h00, 16'h3333);
    issue(HBP_K_DATA_WR, 7'h00, 16'h4444);
    cmp({15'h0000, st[1]}, 16'h0001);
    pulse(1'b1);
    cmp({15'h0000, half}, 16'h0001);
    issue(HBP_K_PORT_RD, CMD_ISO_PORT, 16'h0000);
    issue(HBP_K_DATA_RD, 7'h00, 16'h0000);
    cmp(got, 16'h3333);
    cmp({15'h0000, st[1]}, 16'h0000);
  endtask
  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    sc_ack_stream();
    sc_ack_serviced();
    sc_iso_pingpong();
    tally_and_finish();
  end
endmodule
`default_nettype wire
